// File: src/perf_event_regs.svh
// Summary of operation
// - Counter 2 event selector is perf_control_0 bits 26-31, six bits wide.
// - Selector zero holds the count; selector one counts every cycle.
// - Selector two counts completed instructions, folded branches excluded.
// - Counter 2 code three counts rising edges of timebase bit 15/19/23/31.
// - Counters 3/4 code three count rises of time base bit 47/51/55/63.
// - Selector four adds zero, one or two dispatched instructions per cycle.
// - Counter 2 codes five to twelve count the listed core events.
// - Counter 2 code ten counts L1 load misses above the latency threshold.
// - Counter 3 event selector is perf_control_1 bits 0-4.
// - Counter 4 event selector is perf_control_1 bits 5-9.
// - Counter 3 codes five to eight count cache, translation, branch events.
// - Counter 3 code nine counts mark bit toggles in user mode.
// - Counter 3 codes ten to thirteen count completion and L2 events.
// - Counter 3 codes fifteen to seventeen count miss, speculation, stalls.
// - Counter 4 code five counts L2 castouts, code six data table searches.
// - Counter 4 code eight counts mispredicted branches.
// - Counter 4 code nine counts mark bit toggles in supervisor mode.
// - Counter 4 codes ten to fourteen count the listed events.
// - Counters 1-4 are read and written at special register numbers 953, 954, 957 and 958.
// - Overflow once the top bit is set; interrupt needs both enables.
`ifndef PERF_EVENT_REGS_SVH
`define PERF_EVENT_REGS_SVH

// Special register numbers
`define SPR_CTRL0 10'h3b8
`define SPR_CNT1 10'h3b9
`define SPR_CNT2 10'h3ba
`define SPR_CTRL1 10'h3bc
`define SPR_CNT3 10'h3bd
`define SPR_CNT4 10'h3be

// Field positions, counted from the least significant bit of the register
`define SEL2_LSB 0
`define SEL3_LSB 27
`define SEL4_LSB 22
`define TBSEL_LSB 23
`define CTRL1_MASK 32'hffc0_0000

// Time base bits, counted from the least significant bit of the low word
`define TB_TAP0 16
`define TB_TAP1 12
`define TB_TAP2 8
`define TB_TAP3 0

// Reset values
`define CTRL_RST 32'h0000_0000
`define CNT_RST 32'h0000_0000

`endif

// File: src/perf_event_pkg.sv
package perf_event_pkg;

  typedef logic [31:0] word_t;
  typedef logic [9:0] spr_num_t;
  typedef logic [1:0] inc_t;

  // Selector codes shared by every counter
  typedef enum logic [5:0] {
    SEL_HOLD = 6'h00,
    SEL_CYCLE = 6'h01,
    SEL_COMPLETE = 6'h02,
    SEL_TIMEBASE = 6'h03,
    SEL_DISPATCH = 6'h04
  } common_sel_e;

  // Raw event sources from the core, sampled every cycle
  typedef struct packed {
    inc_t instr_completed;
    inc_t instr_dispatched;
    logic io_barrier_done;
    logic instruction_translation_buffer_search;
    logic l2_hit;
    logic ifetch_valid;
    logic ibreak_match;
    logic threshold_load_miss;
    logic branch_unresolved;
    logic dispatch_stall_2nd;
    logic l1d_miss;
    logic data_translation_buffer_miss;
    logic l2d_miss;
    logic branch_taken;
    logic stcx_done;
    logic fpu_done;
    logic l2_snoop_castout;
    logic cacheop_l2_hit;
    logic l1_load_miss_cycle;
    logic spec2_branch_ok;
    logic bu_dep_stall;
    logic l2_castout;
    logic data_translation_buffer_search;
    logic branch_mispredict;
    logic stcx_reserved_ok;
    logic sync_done;
    logic snoop_retry;
    inc_t int_done;
    logic bu_two_unresolved;
  } events_s;

  // Move to / move from special register request
  typedef struct packed {
    logic wr;
    logic rd;
    spr_num_t num;
    word_t wdata;
  } spr_req_s;

endpackage

// File: src/event_counter_slice.sv
`timescale 1ns/1ps
`include "perf_event_regs.svh"

module event_counter_slice
  import perf_event_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic load,
  input wire word_t load_value,
  input wire logic count_en,
  input wire inc_t inc,
  output word_t value
);

  word_t value_ff;
  word_t nxt_value;

  always_comb begin
    nxt_value = value_ff;
    // A software write wins over an event in the same cycle
    if (load) begin
      nxt_value = load_value;
    end else if (count_en) begin
      nxt_value = value_ff + {30'h0, inc};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      value_ff <= `CNT_RST;
    end else begin
      value_ff <= nxt_value;
    end
  end

  assign value = value_ff;

endmodule // event_counter_slice

// File: src/perf_event_select_counters.sv
`timescale 1ns/1ps
`include "perf_event_regs.svh"

module perf_event_select_counters
  import perf_event_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire spr_req_s spr_req,
  input wire events_s events,
  input wire word_t timebase_lower,
  input wire logic process_mark_bit,
  input wire logic user_mode,
  input wire logic count_enable,
  input wire inc_t counter1_inc,
  input wire logic global_int_enable,
  input wire logic counter1_int_control,
  input wire logic counter_int_control,
  output word_t spr_rdata,
  output logic spr_hit,
  output logic [3:0] overflow,
  output logic int_request,
  output word_t control_0,
  output word_t control_1
);

  // ************************************************************
  // Control registers
  // ************************************************************

  word_t ctrl0_ff;
  word_t ctrl1_ff;
  word_t nxt_ctrl0;
  word_t nxt_ctrl1;
  logic [5:0] sel2;
  logic [4:0] sel3;
  logic [4:0] sel4;
  logic [1:0] tb_select;

  always_comb begin
    nxt_ctrl0 = ctrl0_ff;
    nxt_ctrl1 = ctrl1_ff;
    if (spr_req.wr && spr_req.num == `SPR_CTRL0) begin
      nxt_ctrl0 = spr_req.wdata;
    end
    // Reserved bits of the second control word stay zero
    if (spr_req.wr && spr_req.num == `SPR_CTRL1) begin
      nxt_ctrl1 = spr_req.wdata & `CTRL1_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl0_ff <= `CTRL_RST;
      ctrl1_ff <= `CTRL_RST;
    end else begin
      ctrl0_ff <= nxt_ctrl0;
      ctrl1_ff <= nxt_ctrl1;
    end
  end

  // A new selector takes effect from the cycle after its write
  assign sel2 = ctrl0_ff[`SEL2_LSB +: 6];
  assign sel3 = ctrl1_ff[`SEL3_LSB +: 5];
  assign sel4 = ctrl1_ff[`SEL4_LSB +: 5];
  assign tb_select = ctrl0_ff[`TBSEL_LSB +: 2];

  // ************************************************************
  // Edge detection of time base and mark bit
  // ************************************************************

  logic [3:0] tb_taps;
  logic [3:0] tb_taps_ff;
  logic [3:0] nxt_tb_taps;
  logic mark_ff;
  logic nxt_mark;
  logic tb_rise;
  logic mark_toggle;

  assign tb_taps = {timebase_lower[`TB_TAP3], timebase_lower[`TB_TAP2],
                    timebase_lower[`TB_TAP1], timebase_lower[`TB_TAP0]};

  always_comb begin
    nxt_tb_taps = tb_taps;
    nxt_mark = process_mark_bit;
  end

  // Taps are tracked all the time, so a selector change never sees a
  // false edge from stale history.
  always_ff @(posedge clk) begin
    if (rst) begin
      tb_taps_ff <= 4'h0;
      mark_ff <= 1'b0;
    end else begin
      tb_taps_ff <= nxt_tb_taps;
      mark_ff <= nxt_mark;
    end
  end

  // Bits 15/19/23/31 of the low word equal bits 47/51/55/63 of the base
  assign tb_rise = tb_taps[tb_select] & ~tb_taps_ff[tb_select];
  // Any change of the mark bit counts, in either direction
  assign mark_toggle = process_mark_bit ^ mark_ff;

  // ************************************************************
  // Event selection
  // ************************************************************

  inc_t inc2;
  inc_t inc3;
  inc_t inc4;
  inc_t common_inc;

  // First five codes are shared by all counters
  always_comb begin
    common_inc = 2'h0;
    case (sel2[2:0])
      3'h0: common_inc = 2'h0;
      3'h1: common_inc = 2'h1;
      3'h2: common_inc = events.instr_completed;
      3'h3: common_inc = {1'b0, tb_rise};
      3'h4: common_inc = events.instr_dispatched;
      default: common_inc = 2'h0;
    endcase
  end

  always_comb begin
    inc2 = 2'h0;
    case (sel2)
      6'h00, 6'h01, 6'h02, 6'h03, 6'h04: inc2 = common_inc;
      6'h05: inc2 = {1'b0, events.io_barrier_done};
      6'h06: inc2 = {1'b0, events.instruction_translation_buffer_search};
      6'h07: inc2 = {1'b0, events.l2_hit};
      6'h08: inc2 = {1'b0, events.ifetch_valid};
      6'h09: inc2 = {1'b0, events.ibreak_match};
      6'h0a: inc2 = {1'b0, events.threshold_load_miss};
      6'h0b: inc2 = {1'b0, events.branch_unresolved};
      6'h0c: inc2 = {1'b0, events.dispatch_stall_2nd};
      // Reserved codes count nothing
      default: inc2 = 2'h0;
    endcase
  end

  inc_t cmn3;
  inc_t cmn4;

  // Shared codes re-evaluated on the narrower selectors
  always_comb begin
    cmn3 = 2'h0;
    case (sel3[2:0])
      3'h1: cmn3 = 2'h1;
      3'h2: cmn3 = events.instr_completed;
      3'h3: cmn3 = {1'b0, tb_rise};
      3'h4: cmn3 = events.instr_dispatched;
      default: cmn3 = 2'h0;
    endcase
  end

  always_comb begin
    cmn4 = 2'h0;
    case (sel4[2:0])
      3'h1: cmn4 = 2'h1;
      3'h2: cmn4 = events.instr_completed;
      3'h3: cmn4 = {1'b0, tb_rise};
      3'h4: cmn4 = events.instr_dispatched;
      default: cmn4 = 2'h0;
    endcase
  end

  always_comb begin
    inc3 = 2'h0;
    case (sel3)
      5'h00, 5'h01, 5'h02, 5'h03, 5'h04: inc3 = cmn3;
      5'h05: inc3 = {1'b0, events.l1d_miss};
      5'h06: inc3 = {1'b0, events.data_translation_buffer_miss};
      5'h07: inc3 = {1'b0, events.l2d_miss};
      5'h08: inc3 = {1'b0, events.branch_taken};
      5'h09: inc3 = {1'b0, mark_toggle & user_mode};
      5'h0a: inc3 = {1'b0, events.stcx_done};
      5'h0b: inc3 = {1'b0, events.fpu_done};
      5'h0c: inc3 = {1'b0, events.l2_snoop_castout};
      5'h0d: inc3 = {1'b0, events.cacheop_l2_hit};
      5'h0f: inc3 = {1'b0, events.l1_load_miss_cycle};
      5'h10: inc3 = {1'b0, events.spec2_branch_ok};
      5'h11: inc3 = {1'b0, events.bu_dep_stall};
      // Reserved codes count nothing
      default: inc3 = 2'h0;
    endcase
  end

  always_comb begin
    inc4 = 2'h0;
    case (sel4)
      5'h00, 5'h01, 5'h02, 5'h03, 5'h04: inc4 = cmn4;
      5'h05: inc4 = {1'b0, events.l2_castout};
      5'h06: inc4 = {1'b0, events.data_translation_buffer_search};
      5'h08: inc4 = {1'b0, events.branch_mispredict};
      5'h09: inc4 = {1'b0, mark_toggle & ~user_mode};
      5'h0a: inc4 = {1'b0, events.stcx_reserved_ok};
      5'h0b: inc4 = {1'b0, events.sync_done};
      5'h0c: inc4 = {1'b0, events.snoop_retry};
      5'h0d: inc4 = events.int_done;
      5'h0e: inc4 = {1'b0, events.bu_two_unresolved};
      // Reserved codes count nothing
      default: inc4 = 2'h0;
    endcase
  end

  // ************************************************************
  // Counters
  // ************************************************************

  logic [3:0] load;
  word_t cnt [4];
  inc_t inc [4];

  // Counter writes decode here; the slice lets a write beat an event
  always_comb begin
    load[0] = spr_req.wr && spr_req.num == `SPR_CNT1;
    load[1] = spr_req.wr && spr_req.num == `SPR_CNT2;
    load[2] = spr_req.wr && spr_req.num == `SPR_CNT3;
    load[3] = spr_req.wr && spr_req.num == `SPR_CNT4;
    inc[0] = counter1_inc;
    inc[1] = inc2;
    inc[2] = inc3;
    inc[3] = inc4;
  end

  // Counter 1 keeps only its load and read here; its event choice is outside
  for (genvar i = 0; i < 4; i++) begin : g_cnt
    event_counter_slice event_counter_slice_inst (
      .clk(clk),
      .rst(rst),
      .load(load[i]),
      .load_value(spr_req.wdata),
      .count_en(count_enable),
      .inc(inc[i]),
      .value(cnt[i])
    );
  end

  // ************************************************************
  // Read port, overflow and interrupt request
  // ************************************************************

  word_t rdata_ff;
  word_t nxt_rdata;
  logic hit_ff;
  logic nxt_hit;
  logic [3:0] ovf_ff;
  logic [3:0] nxt_ovf;
  logic irq_ff;
  logic nxt_irq;

  // Read data is zero outside a mapped read, so it can be ORed onto a bus
  always_comb begin
    nxt_rdata = 32'h0;
    nxt_hit = spr_req.rd;
    if (spr_req.rd) begin
      case (spr_req.num)
        `SPR_CTRL0: nxt_rdata = ctrl0_ff;
        `SPR_CTRL1: nxt_rdata = ctrl1_ff;
        `SPR_CNT1: nxt_rdata = cnt[0];
        `SPR_CNT2: nxt_rdata = cnt[1];
        `SPR_CNT3: nxt_rdata = cnt[2];
        `SPR_CNT4: nxt_rdata = cnt[3];
        default: nxt_hit = 1'b0;
      endcase
    end
  end

  // Overflow follows the sign bit; a software load of a value with the
  // sign bit set raises it too, with no event counted.
  always_comb begin
    nxt_ovf = {cnt[3][31], cnt[2][31], cnt[1][31], cnt[0][31]};
    // Built from the registered flags: one more cycle of lag, shorter path
    nxt_irq = global_int_enable &
              ((counter1_int_control & ovf_ff[0]) |
               (counter_int_control & |ovf_ff[3:1]));
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_ff <= 32'h0;
      hit_ff <= 1'b0;
      ovf_ff <= 4'h0;
      irq_ff <= 1'b0;
    end else begin
      rdata_ff <= nxt_rdata;
      hit_ff <= nxt_hit;
      ovf_ff <= nxt_ovf;
      irq_ff <= nxt_irq;
    end
  end

  assign spr_rdata = rdata_ff;
  assign spr_hit = hit_ff;
  assign overflow = ovf_ff;
  assign int_request = irq_ff;
  assign control_0 = ctrl0_ff;
  assign control_1 = ctrl1_ff;

endmodule // perf_event_select_counters

// File: tb/perf_event_select_counters_props.sv
`timescale 1ns/1ps
`include "perf_event_regs.svh"

module perf_event_select_counters_props
  import perf_event_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire spr_req_s spr_req,
  input wire logic global_int_enable,
  input wire logic counter1_int_control,
  input wire logic counter_int_control,
  input wire word_t spr_rdata,
  input wire logic spr_hit,
  input wire logic [3:0] overflow,
  input wire logic int_request,
  input wire word_t control_0,
  input wire word_t control_1
);
  // ****************************************
  // Register port and overflow checks
  // ****************************************
  logic mapped;
  logic int_cond;
  assign mapped = spr_req.num inside {`SPR_CTRL0, `SPR_CNT1, `SPR_CNT2,
    `SPR_CTRL1, `SPR_CNT3, `SPR_CNT4};
  assign int_cond = global_int_enable & (counter1_int_control & overflow[0]
    | counter_int_control & (|overflow[3:1]));
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  read_hit_a: assert property (spr_req.rd && mapped |=> spr_hit)
    else $error("mapped read not acknowledged");
  read_miss_a: assert property (spr_req.rd && !mapped |=>
    !spr_hit && spr_rdata == '0) else $error("unmapped read answered");
  read_idle_a: assert property (!spr_req.rd |=>
    !spr_hit && spr_rdata == '0) else $error("read data without request");
  ctrl0_write_a: assert property (spr_req.wr &&
    spr_req.num == `SPR_CTRL0 |=> control_0 == $past(spr_req.wdata))
    else $error("control 0 write lost");
  ctrl1_write_a: assert property (spr_req.wr &&
    spr_req.num == `SPR_CTRL1 |=>
    control_1 == ($past(spr_req.wdata) & `CTRL1_MASK))
    else $error("control 1 write wrong");
  ctrl1_resv_a: assert property (control_1[21:0] == '0)
    else $error("control 1 reserved bits set");
  ovf_flag_a: assert property (spr_req.wr &&
    spr_req.num == `SPR_CNT3 && spr_req.wdata[31:30] == 2'b10 |->
    ##2 overflow[2]) else $error("overflow flag missing");
  int_req_a: assert property (1'b1 |=>
    int_request == $past(int_cond)) else $error("interrupt request wrong");
endmodule // perf_event_select_counters_props

bind perf_event_select_counters perf_event_select_counters_props
  props_inst (.clk(clk), .rst(rst), .spr_req(spr_req),
  .global_int_enable(global_int_enable),
  .counter1_int_control(counter1_int_control),
  .counter_int_control(counter_int_control), .spr_rdata(spr_rdata),
  .spr_hit(spr_hit), .overflow(overflow), .int_request(int_request),
  .control_0(control_0), .control_1(control_1));

// File: tb/tb_perf_event_select_counters.sv
`timescale 1ns/1ps
`include "perf_event_regs.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin failures++; \
  $display("mismatch t=%0t got %h exp %h", $time, g, e); end end

module tb_perf_event_select_counters
  import perf_event_pkg::*;
;
  logic clk = 0;
  logic rst = 1;
  spr_req_s spr_req = '0;
  events_s events = '0;
  word_t timebase_lower = '0;
  logic process_mark_bit = 0;
  logic user_mode = 0;
  logic count_enable = 0;
  inc_t counter1_inc = '0;
  logic global_int_enable = 0;
  logic counter1_int_control = 0;
  logic counter_int_control = 0;
  word_t spr_rdata, control_0, control_1;
  logic spr_hit, int_request;
  logic [3:0] overflow;
  int failures = 0;
  int checks_done = 0;
  int ev_bit;
  int tap[4] = '{16, 12, 8, 0};
  int c4[8] = '{5, 6, 8, 10, 11, 12, 13, 14};
  int p4[8] = '{8, 7, 6, 5, 4, 3, 1, 0};

  always #12.5 clk = ~clk;

  perf_event_select_counters perf_event_select_counters_inst (.clk(clk),
    .rst(rst), .spr_req(spr_req), .events(events),
    .timebase_lower(timebase_lower), .process_mark_bit(process_mark_bit),
    .user_mode(user_mode), .count_enable(count_enable),
    .counter1_inc(counter1_inc), .global_int_enable(global_int_enable),
    .counter1_int_control(counter1_int_control),
    .counter_int_control(counter_int_control), .spr_rdata(spr_rdata),
    .spr_hit(spr_hit), .overflow(overflow), .int_request(int_request),
    .control_0(control_0), .control_1(control_1));

  // ****************************************
  // Register access tasks
  // ****************************************
  function automatic spr_num_t cnum(input int c);
    return c == 1 ? `SPR_CNT1 : c == 2 ? `SPR_CNT2 :
      c == 3 ? `SPR_CNT3 : `SPR_CNT4;
  endfunction

  task automatic wr(input spr_num_t n, input word_t d);
    @(negedge clk);
    spr_req.wr = 1;
    spr_req.num = n;
    spr_req.wdata = d;
    @(negedge clk);
    spr_req.wr = 0;
  endtask

  task automatic rd(input spr_num_t n, input word_t e, input logic h);
    @(negedge clk);
    spr_req.rd = 1;
    spr_req.num = n;
    @(negedge clk);
    spr_req.rd = 0;
    `CHK(spr_hit, h)
    `CHK(spr_rdata, e)
  endtask

  // Counting is gated so each run covers exactly n rising edges
  task automatic run(input int n, input word_t tbm, input logic mt);
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      count_enable = 1;
      timebase_lower = i[0] ? tbm : '0;
      if (mt) process_mark_bit = ~process_mark_bit;
    end
    @(negedge clk);
    count_enable = 0;
    timebase_lower = '0;
  endtask

  task automatic tally(input int c, input int code, input word_t ev,
                       input int n, input word_t e);
    wr(`SPR_CTRL0, c == 2 ? word_t'(code) : '0);
    wr(`SPR_CTRL1, c == 3 ? word_t'(code) << 27 :
      c == 4 ? word_t'(code) << 22 : '0);
    wr(cnum(c), '0);
    events = events_s'(ev);
    run(n, '0, 0);
    events = '0;
    rd(cnum(c), e, 1);
  endtask

  task automatic complete_run();
    $display("checks_done %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    repeat (4) @(negedge clk);
    rst = 0;
    for (int c = 1; c < 5; c++) rd(cnum(c), '0, 1);
    rd(`SPR_CTRL0, '0, 1);
    rd(10'h3bb, '0, 0);
    for (int c = 1; c < 5; c++) begin
      wr(cnum(c), 32'h8765_4320 + c);
      rd(cnum(c), 32'h8765_4320 + c, 1);
    end
    wr(`SPR_CTRL1, '1);
    `CHK(control_1, `CTRL1_MASK)
    rd(`SPR_CTRL1, `CTRL1_MASK, 1);
    for (int c = 2; c < 5; c++) begin
      tally(c, 0, '1, 4, 0);
      tally(c, 1, '0, 7, 7);
      tally(c, 2, 32'h8000_0000, 3, 6);
      tally(c, 4, 32'h2000_0000, 3, 6);
    end
    for (int k = 5; k < 13; k++) begin
      tally(2, k, 32'h1 << (32 - k), 3, 3);
    end
    for (int k = 5; k < 18; k++) begin
      if (k != 9 && k != 14) begin
        ev_bit = k < 9 ? 24 - k : k < 14 ? 25 - k : 26 - k;
        tally(3, k, 32'h1 << ev_bit, 3, 3);
      end
    end
    for (int i = 0; i < 8; i++) begin
      tally(4, c4[i], 32'h1 << p4[i], 3, 3);
    end
    tally(2, 13, '1, 3, 0);
    tally(3, 14, '1, 3, 0);
    tally(4, 7, '1, 3, 0);
    // All four counters advance together in one run
    wr(`SPR_CTRL0, 32'h1);
    `CHK(control_0, 32'h1)
    wr(`SPR_CTRL1, 32'h0840_0000);
    for (int c = 1; c < 5; c++) wr(cnum(c), '0);
    counter1_inc = 2'h2;
    run(5, '0, 0);
    counter1_inc = '0;
    rd(cnum(1), 32'ha, 1);
    for (int c = 2; c < 5; c++) begin
      rd(cnum(c), 32'h5, 1);
    end
    for (int s = 0; s < 4; s++) begin
      wr(`SPR_CTRL0, (word_t'(s) << 23) | 32'h3);
      wr(`SPR_CTRL1, 32'h18c0_0000);
      for (int c = 2; c < 5; c++) wr(cnum(c), '0);
      run(6, ~(32'h1 << tap[s]), 0);
      run(6, 32'h1 << tap[s], 0);
      for (int c = 2; c < 5; c++) rd(cnum(c), 32'h3, 1);
    end
    wr(`SPR_CTRL0, '0);
    wr(`SPR_CTRL1, 32'h4a40_0000);
    wr(cnum(3), '0);
    wr(cnum(4), '0);
    user_mode = 1;
    run(5, '0, 1);
    user_mode = 0;
    run(4, '0, 1);
    rd(cnum(3), 32'h5, 1);
    rd(cnum(4), 32'h4, 1);
    wr(cnum(3), 32'h8000_0000);
    repeat (3) @(negedge clk);
    `CHK(overflow, 4'b0100)
    `CHK(int_request, 1'b0)
    global_int_enable = 1;
    counter_int_control = 1;
    repeat (3) @(negedge clk);
    `CHK(int_request, 1'b1)
    counter_int_control = 0;
    counter1_int_control = 1;
    repeat (3) @(negedge clk);
    `CHK(int_request, 1'b0)
    wr(cnum(1), 32'h8000_0000);
    repeat (3) @(negedge clk);
    `CHK(overflow, 4'b0101)
    `CHK(int_request, 1'b1)
    // Counting across the sign bit raises the flag as well
    wr(`SPR_CTRL0, 32'h1);
    wr(cnum(2), 32'h7fff_fffe);
    run(2, '0, 0);
    repeat (2) @(negedge clk);
    `CHK(overflow, 4'b0111)
    rd(cnum(2), 32'h8000_0000, 1);
    complete_run();
  end

  // Whole sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    complete_run();
  end
endmodule // tb_perf_event_select_counters
